// [bdm_ee_model.sv]
// Stand-in for the EEPROM control register; flips per access so stale reads show
`timescale 1ns/1ps
module bdm_ee_model (
  input wire logic clk,
  input wire logic sel,
  output logic [7:0] rdata
);
  logic [7:0] val_q = 8'hA5;
  always_ff @(posedge clk) val_q <= val_q ^ {8{sel}};
  assign rdata = val_q;
endmodule : bdm_ee_model

// [bdm_gp_if.sv]
// Interface carrying general purpose storage accesses
`timescale 1ns/1ps
interface bdm_gp_if;
  logic we;
  logic [1:0] bank;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic hit;
  modport ctl (output we, output bank, output addr, output wdata, input rdata, input hit);
  modport mem (input we, input bank, input addr, input wdata, output rdata, output hit);
endinterface : bdm_gp_if

// [bdm_gp_store.sv]
// General purpose storage banks
`timescale 1ns/1ps
module bdm_gp_store
  import bdm_pkg::*;
#(
  parameter bit HAS_BANK2 = 1'b1
) (
  input wire logic clk,
  bdm_gp_if.mem gp
);
  // ****************************************
  // Storage arrays
  // ****************************************
  logic [7:0] bank0_mem [int'(GP_B0_LO):int'(GP_B0_HI)];
  logic [7:0] bank1_mem [int'(GP_B1_LO):int'(GP_B1_HI)];
  logic [7:0] bank2_mem [int'(GP_B2_LO):int'(GP_B2_HI)];
  logic in0, in1, in2;

  always_comb begin
    in0 = (gp.bank == BANK_0) && (gp.addr >= GP_B0_LO);
    in1 = (gp.bank == BANK_1) && (gp.addr >= GP_B1_LO);
    in2 = HAS_BANK2 && (gp.bank == BANK_2) && (gp.addr >= GP_B2_LO) &&
          (gp.addr <= GP_B2_HI);
    gp.hit = in0 || in1 || in2;
    // Out of range reads give zero
    gp.rdata = 8'h00;
    if (in0) begin
      gp.rdata = bank0_mem[gp.addr];
    end else if (in1) begin
      gp.rdata = bank1_mem[gp.addr];
    end else if (in2) begin
      gp.rdata = bank2_mem[gp.addr];
    end
  end

  // Unprotected byte writes; no reset since the storage is volatile
  always_ff @(posedge clk) begin
    if (gp.we && in0) begin
      bank0_mem[gp.addr] <= gp.wdata;
    end
    if (gp.we && in1) begin
      bank1_mem[gp.addr] <= gp.wdata;
    end
    if (gp.we && in2) begin
      bank2_mem[gp.addr] <= gp.wdata;
    end
  end
endmodule : bdm_gp_store

// [bdm_pkg.sv]
// Package with address map and constants for the banked data memory
package bdm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int BANK_W = 2;
  localparam logic [7:0] ADDR_ALIAS_FIRST = 8'h00;
  localparam logic [7:0] ADDR_PTR_FIRST = 8'h01;
  localparam logic [7:0] ADDR_ALIAS_SECOND = 8'h02;
  localparam logic [7:0] ADDR_PTR_SECOND = 8'h03;
  localparam logic [7:0] ADDR_BANK_SEL = 8'h04;
  localparam logic [7:0] ADDR_EEPROM_CTRL = 8'h40;
  localparam logic [7:0] GP_B0_LO = 8'h60;
  localparam logic [7:0] GP_B0_HI = 8'hFF;
  localparam logic [7:0] GP_B1_LO = 8'h80;
  localparam logic [7:0] GP_B1_HI = 8'hFF;
  localparam logic [7:0] GP_B2_LO = 8'h80;
  localparam logic [7:0] GP_B2_HI = 8'hDF;
  localparam logic [1:0] BANK_0 = 2'h0;
  localparam logic [1:0] BANK_1 = 2'h1;
  localparam logic [1:0] BANK_2 = 2'h2;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_BANK = 2'h0;
endpackage : bdm_pkg

// [bdm_props.sv]
// Property checker for the banked data memory ports
`timescale 1ns/1ps
module bdm_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic acc_rd,
  input wire logic acc_wr,
  input wire logic [7:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] acc_rdata,
  input wire logic acc_rvalid,
  input wire logic eeprom_ctrl_sel,
  input wire logic [7:0] memory_pointer_first,
  input wire logic [1:0] bank_select_register
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_read_answer: assert property (acc_rvalid == $past(acc_rd)) else $error("rvalid");
  a_rdata_held: assert property (!acc_rd |=> $stable(acc_rdata)) else $error("rdata");
  a_bank_held: assert property (!acc_wr |-> ##2 $stable(bank_select_register))
    else $error("bank held");
  a_bank_write: assert property (acc_wr && acc_addr == 8'h04 |-> ##2
    bank_select_register == $past(acc_wdata[1:0], 2)) else $error("bank value");
  a_eeprom_sel: assert property (acc_rd && acc_addr == 8'h40 |=>
    eeprom_ctrl_sel == ($past(bank_select_register) == 2'h1)) else $error("select");
  a_idle_quiet: assert property (!acc_rd && !acc_wr |=> !eeprom_ctrl_sel) else $error("idle");
  a_special_zero: assert property (acc_rd && acc_addr inside {[8'h05:8'h3F]} |=>
    acc_rdata == 8'h00) else $error("special");
  a_pointer_copy: assert property (acc_wr && acc_addr == 8'h01 ##1 !acc_wr [*2] |->
    memory_pointer_first == $past(acc_wdata, 2)) else $error("pointer");
endmodule : bdm_props
bind bdm_top bdm_props chk_u (.*);

// [bdm_top.sv]
// Banked data memory addressing unit for the core data path
//
// What this block does
// - Every location is one volatile byte.
// - Special registers appear in all banks; EEPROM control at 40H only in bank 1.
// - The active bank changes only on a write to the bank select register.
// - Addresses start at zero, special area lowest.
// - General storage 60H-FFH bank 0, 80H-FFH bank 1, 80H-DFH bank 2 if present.
// - All general locations are freely readable and writable.
// - Alias accesses act on the location held in the paired pointer.
// - First pair reaches bank 0 only; second pair uses the bank select.
// - Indirect access to an alias address reads zero and writes nothing.
// - Only the two low bank select bits choose banks 0 to 2.
// - Direct addressing reaches bank 0 storage; a direct access to 40H follows the bank select.
`timescale 1ns/1ps
module bdm_top
  import bdm_pkg::*;
#(
  parameter bit HAS_BANK2 = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic acc_rd,
  input wire logic acc_wr,
  input wire logic [7:0] acc_addr,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] eeprom_ctrl_rdata,
  output logic [7:0] acc_rdata,
  output logic acc_rvalid,
  output logic eeprom_ctrl_sel,
  output logic [7:0] memory_pointer_first,
  output logic [7:0] memory_pointer_second,
  output logic [1:0] bank_select_register
);
  // ****************************************
  // Local state
  // ****************************************
  logic [7:0] mp0_q;
  logic [7:0] mp1_q;
  logic [7:0] bp_q;
  logic [7:0] eff_addr;
  logic [1:0] eff_bank;
  logic alias_to_alias;
  logic is_indirect;
  logic sfr_space;
  logic eec_hit;
  logic [7:0] rd_d;
  logic eec_sel_d;
  bdm_gp_if gp();

  // ****************************************
  // Address resolution
  // ****************************************
  always_comb begin
    is_indirect = 1'b0;
    eff_addr = acc_addr;
    eff_bank = BANK_0;
    if (acc_addr == ADDR_ALIAS_FIRST) begin
      is_indirect = 1'b1;
      eff_addr = mp0_q;
      eff_bank = BANK_0;
    end else if (acc_addr == ADDR_ALIAS_SECOND) begin
      is_indirect = 1'b1;
      eff_addr = mp1_q;
      eff_bank = bp_q[1:0];
    end
    alias_to_alias = is_indirect &&
                     (eff_addr == ADDR_ALIAS_FIRST || eff_addr == ADDR_ALIAS_SECOND);
    sfr_space = eff_addr < GP_B0_LO;
    // Special area is mirrored, so a direct access sees the selected bank here
    eec_hit = (eff_addr == ADDR_EEPROM_CTRL) &&
              ((is_indirect ? eff_bank : bp_q[1:0]) == BANK_1);
  end

  assign gp.bank = eff_bank;
  assign gp.addr = eff_addr;
  assign gp.wdata = acc_wdata;
  // Special area is shared across banks, so it never reaches bank storage
  assign gp.we = acc_wr && !sfr_space && !alias_to_alias;

  bdm_gp_store #(.HAS_BANK2(HAS_BANK2)) u_store (
    .clk(clk),
    .gp(gp)
  );

  // ****************************************
  // Pointer and bank select registers
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mp0_q <= RST_BYTE;
      mp1_q <= RST_BYTE;
    end else if (acc_wr && !alias_to_alias) begin
      if (eff_addr == ADDR_PTR_FIRST) begin
        mp0_q <= acc_wdata;
      end
      if (eff_addr == ADDR_PTR_SECOND) begin
        mp1_q <= acc_wdata;
      end
    end
  end

  // Bank changes only on a write that lands on the bank select register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bp_q <= RST_BYTE;
    end else if (acc_wr && !alias_to_alias && eff_addr == ADDR_BANK_SEL) begin
      bp_q <= acc_wdata;
    end
  end

  // ****************************************
  // Read return
  // ****************************************
  always_comb begin
    rd_d = 8'h00;
    eec_sel_d = 1'b0;
    if (alias_to_alias) begin
      rd_d = 8'h00;
    end else if (eff_addr == ADDR_PTR_FIRST) begin
      rd_d = mp0_q;
    end else if (eff_addr == ADDR_PTR_SECOND) begin
      rd_d = mp1_q;
    end else if (eff_addr == ADDR_BANK_SEL) begin
      rd_d = bp_q;
    end else if (eec_hit) begin
      rd_d = eeprom_ctrl_rdata;
      eec_sel_d = 1'b1;
    end else if (!sfr_space) begin
      rd_d = gp.rdata;
    end
  end

  // Registered answer keeps every output straight from a flop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_rdata <= RST_BYTE;
      acc_rvalid <= 1'b0;
    end else begin
      acc_rvalid <= acc_rd;
      if (acc_rd) begin
        acc_rdata <= rd_d;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      eeprom_ctrl_sel <= 1'b0;
      memory_pointer_first <= RST_BYTE;
      memory_pointer_second <= RST_BYTE;
      bank_select_register <= RST_BANK;
    end else begin
      eeprom_ctrl_sel <= eec_sel_d && (acc_rd || acc_wr);
      memory_pointer_first <= mp0_q;
      memory_pointer_second <= mp1_q;
      bank_select_register <= bp_q[1:0];
    end
  end
endmodule : bdm_top

// [tb_top.sv]
// Self-checking testbench for the banked data memory
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, nrst = 1'b0, acc_rd = 1'b0, acc_wr = 1'b0;
  logic acc_rvalid, eeprom_ctrl_sel;
  logic [7:0] acc_addr = 8'h00, acc_wdata = 8'h00, acc_rdata;
  logic [7:0] eeprom_ctrl_rdata, memory_pointer_first, memory_pointer_second;
  logic [1:0] bank_select_register;
  int errors = 0, checks = 0;
  always #4 clk = ~clk;
  bdm_top dut_u (.*);
  bdm_ee_model ee_u (.clk(clk), .sel(eeprom_ctrl_sel), .rdata(eeprom_ctrl_rdata));
  task stop_test();
    if (errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task check(string name, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) errors++;
    if (seen !== exp) $display("BAD %s exp %h seen %h", name, exp, seen);
  endtask : check
  task put(logic [7:0] a, logic [7:0] d);
    {acc_rd, acc_wr, acc_addr, acc_wdata} = {2'b01, a, d};
    @(negedge clk);
  endtask : put
  task get(logic [7:0] a, logic [7:0] exp);
    {acc_rd, acc_wr, acc_addr} = {2'b10, a};
    @(negedge clk);
    check($sformatf("rdata_%h", a), acc_rdata, exp);
    check("rvalid", {7'h00, acc_rvalid}, 8'h01);
  endtask : get
  task t_alias();
    put(8'h60, 8'h11);
    put(8'h01, 8'h60);
    get(8'h00, 8'h11);
    get(8'h05, 8'h00);
    put(8'h01, 8'h02);
    put(8'h00, 8'h99);
    get(8'h00, 8'h00);
  endtask : t_alias
  task t_bank();
    put(8'h80, 8'h55);
    put(8'h03, 8'h80);
    put(8'h04, 8'h05);
    check("mp_second", memory_pointer_second, 8'h80);
    put(8'h02, 8'h44);
    check("bank", {6'h00, bank_select_register}, 8'h01);
    get(8'h80, 8'h55);
    get(8'h02, 8'h44);
    get(8'h40, 8'hA5);
    put(8'h04, 8'h02);
    put(8'h03, 8'hDF);
    put(8'h02, 8'h66);
    get(8'h02, 8'h66);
    put(8'h03, 8'hE0);
    get(8'h02, 8'h00);
  endtask : t_bank
  initial begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    t_alias();
    t_bank();
    stop_test();
  end
  initial begin
    #2000;
    errors++;
    stop_test();
  end
endmodule : tb_top
